//--- clamp_cfg_map.vh
`ifndef CLAMP_CFG_MAP_VH
`define CLAMP_CFG_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_OUTPUT_CODE 8'h05
`define ADDR_CONV_SELECT 8'h06
`define ADDR_CLAMP_CONFIG 8'h07
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_OUTPUT_CODE 16'h0000
`define RST_CONV_SELECT 16'h0000
`define RST_CLAMP_CONFIG 16'h0000
`define RST_SEL_A 1'h0
`define RST_SEL_RSVD 15'h0000
// ----------------------------------------
// field positions
// ----------------------------------------
`define SEL_A_BIT 0
`define RSVD_HI 15
`define RSVD_LO 12
`define MODE_HI 11
`define MODE_LO 10
`define POS_HI 9
`define POS_LO 6
`define NEG_HI 5
`define NEG_LO 2
`define ARM_HI 1
`define ARM_LO 0
// ----------------------------------------
// clamp modes
// ----------------------------------------
`define MODE_TRACK 2'h0
`define MODE_MANUAL 2'h1
`define MODE_LEARN 2'h2
`define MODE_BAD 2'h3
`define POS_RESET 4'h0
`endif

//--- clamp_apply.v
`timescale 1ns/100ps
`default_nettype none
`include "clamp_cfg_map.vh"
// effective clamp levels seen by the converter control
module clamp_apply (
    input wire core_clk,
    input wire srst,
    input wire [1:0] mode,
    input wire [3:0] pos_sw,
    input wire [3:0] neg_sw,
    output reg tracking_r,
    output reg [3:0] pos_eff_r,
    output reg [3:0] neg_eff_r
);
    always @(posedge core_clk) begin
        if (srst) begin
            tracking_r <= 1'b1;
            pos_eff_r <= `POS_RESET;
            neg_eff_r <= 4'h0;
        end else begin
            // mode 11 is not blocked on write; treat it like tracking for safety
            tracking_r <= (mode != `MODE_MANUAL) && (mode != `MODE_LEARN);
            pos_eff_r <= pos_sw;
            neg_eff_r <= neg_sw;
        end
    end
endmodule
`default_nettype wire

//--- dcdc_clamp_config_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "clamp_cfg_map.vh"
module dcdc_clamp_config_regs #(
    parameter ADDR_W = 8
) (
    input wire core_clk,
    input wire srst,
    input wire [ADDR_W-1:0] addr,
    input wire [15:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [15:0] rdata_r,
    output reg [15:0] output_code_r,
    output reg converter_a_select_r,
    output reg [1:0] clamp_mode_r,
    output reg [1:0] arm_enable_r,
    output reg clamp_tracking_r,
    output reg [3:0] pos_clamp_eff_r,
    output reg [3:0] neg_clamp_eff_r,
    input wire learn_valid,
    input wire [3:0] learn_level
);
    // ----------------------------------------
    // register storage
    // ----------------------------------------
    reg [14:0] sel_rsvd_r;
    reg [3:0] cfg_rsvd_r;
    reg [3:0] pos_level_r;
    reg [3:0] neg_level_r;
    wire hit_code = wr_en && (addr == `ADDR_OUTPUT_CODE);
    wire hit_sel = wr_en && (addr == `ADDR_CONV_SELECT);
    wire hit_cfg = wr_en && (addr == `ADDR_CLAMP_CONFIG);
    wire tracking;
    wire [3:0] pos_eff;
    wire [3:0] neg_eff;

    always @(posedge core_clk) begin
        if (srst) begin
            output_code_r <= `RST_OUTPUT_CODE;
            converter_a_select_r <= `RST_SEL_A;
            sel_rsvd_r <= `RST_SEL_RSVD;
            cfg_rsvd_r <= 4'h0;
            clamp_mode_r <= `MODE_TRACK;
            pos_level_r <= `POS_RESET;
            neg_level_r <= 4'h0;
            arm_enable_r <= 2'h0;
        end else begin
            if (hit_code) begin
                output_code_r <= wdata;
            end
            if (hit_sel) begin
                converter_a_select_r <= wdata[`SEL_A_BIT];
                sel_rsvd_r <= wdata[15:1];
            end
            if (hit_cfg) begin
                cfg_rsvd_r <= wdata[`RSVD_HI:`RSVD_LO];
                clamp_mode_r <= wdata[`MODE_HI:`MODE_LO];
                neg_level_r <= wdata[`NEG_HI:`NEG_LO];
                arm_enable_r <= wdata[`ARM_HI:`ARM_LO];
            end
            // learned value wins over software while in auto learn
            if (clamp_mode_r == `MODE_LEARN) begin
                if (learn_valid) begin
                    pos_level_r <= learn_level;
                end
            end else if (hit_cfg) begin
                pos_level_r <= wdata[`POS_HI:`POS_LO];
            end
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (srst) begin
            rdata_r <= 16'h0000;
        end else if (rd_en) begin
            case (addr)
                `ADDR_OUTPUT_CODE: rdata_r <= output_code_r;
                `ADDR_CONV_SELECT: rdata_r <= {sel_rsvd_r,
                    converter_a_select_r};
                `ADDR_CLAMP_CONFIG: rdata_r <= {cfg_rsvd_r, clamp_mode_r,
                    pos_level_r, neg_level_r, arm_enable_r};
                default: rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    clamp_apply u_apply (
        .core_clk(core_clk),
        .srst(srst),
        .mode(clamp_mode_r),
        .pos_sw(pos_level_r),
        .neg_sw(neg_level_r),
        .tracking_r(tracking),
        .pos_eff_r(pos_eff),
        .neg_eff_r(neg_eff)
    );

    always @(posedge core_clk) begin
        if (srst) begin
            clamp_tracking_r <= 1'b1;
            pos_clamp_eff_r <= `POS_RESET;
            neg_clamp_eff_r <= 4'h0;
        end else begin
            clamp_tracking_r <= tracking;
            pos_clamp_eff_r <= pos_eff;
            neg_clamp_eff_r <= neg_eff;
        end
    end
endmodule
`default_nettype wire

//--- clamp_cfg_props.sv
`timescale 1ns/100ps
`default_nettype none
module clamp_cfg_props #(
    parameter ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] rdata_r,
    input wire logic [15:0] output_code_r,
    input wire logic converter_a_select_r,
    input wire logic [1:0] clamp_mode_r,
    input wire logic clamp_tracking_r,
    input wire logic [3:0] pos_clamp_eff_r,
    input wire logic [3:0] neg_clamp_eff_r,
    input wire logic learn_valid,
    input wire logic [3:0] learn_level
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire logic wr5 = wr_en && addr == 8'h05;
    wire logic wr7 = wr_en && addr == 8'h07;
    wire logic md1 = clamp_mode_r == 2'h1;
    wire logic md2 = clamp_mode_r == 2'h2;
    sequence s_track; clamp_mode_r == 2'h0 [*3]; endsequence
    sequence s_man; wr7 && md1 && wdata[11:10] == 2'h1; endsequence
    a_code_write: assert property (wr5 |=> output_code_r == $past(wdata))
        else $error("code not stored");
    a_code_read: assert property (rd_en && addr == 8'h05 |=>
        rdata_r == $past(output_code_r)) else $error("code readback");
    a_select_write: assert property (wr_en && addr == 8'h06 |=>
        converter_a_select_r == $past(wdata[0])) else $error("select lost");
    a_mode_write: assert property (wr7 |=>
        clamp_mode_r == $past(wdata[11:10])) else $error("mode lost");
    a_track_hold: assert property (s_track |-> clamp_tracking_r)
        else $error("tracking off");
    a_manual_apply: assert property (s_man |-> ##3
        {pos_clamp_eff_r, neg_clamp_eff_r} == $past(wdata[9:2], 3))
        else $error("manual levels");
    a_learn_fill: assert property (md2 && learn_valid |-> ##3
        pos_clamp_eff_r == $past(learn_level, 3)) else $error("learn level");
    // mode held for four cycles means no write can reach the field
    a_learn_lock: assert property ((md2 && !learn_valid) [*4] |->
        $stable(pos_clamp_eff_r)) else $error("learn field moved");
endmodule
bind dcdc_clamp_config_regs clamp_cfg_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

//--- test_dcdc_clamp_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_dcdc_clamp_config_regs;
    logic core_clk = 0, srst = 1, wr_en = 0, rd_en = 0, learn_valid = 0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata_r, output_code_r;
    logic [3:0] learn_level = 4'h0, pos_clamp_eff_r, neg_clamp_eff_r;
    logic [1:0] clamp_mode_r, arm_enable_r;
    logic converter_a_select_r, clamp_tracking_r;
    int err_count = 0, total_checks = 0;
    dcdc_clamp_config_regs dut_u (.*);
    initial forever #4 core_clk = ~core_clk;
    task print_verdict; begin
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    end endtask
    task chk(input string n, input [15:0] s, input [15:0] e); begin
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    end endtask
    task wr(input [7:0] a, input [15:0] d); begin
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1;
        @(posedge core_clk);
        wr_en <= 0;
    end endtask
    task rd(input [7:0] a, input [15:0] e); begin
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1;
        @(posedge core_clk);
        rd_en <= 0;
        #1 chk("rdata", rdata_r, e);
    end endtask
    // applied levels trail the stored fields by two cycles
    task lvl(input [15:0] e); begin
        repeat (3) @(posedge core_clk);
        #1 chk("levels", {7'h0, clamp_tracking_r, pos_clamp_eff_r,
            neg_clamp_eff_r}, e);
    end endtask
    initial begin
        #5000 err_count++;
        print_verdict;
    end
    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 0;
        rd(8'h05, 16'h0000);
        rd(8'h06, 16'h0000);
        rd(8'h07, 16'h0000);
        wr(8'h05, 16'hA5C3);
        wr(8'h06, 16'hFFFF);
        rd(8'h06, 16'hFFFF);
        wr(8'h07, 16'h03FC);
        lvl(16'h01FF);
        wr(8'h07, 16'h0625);
        lvl(16'h0089);
        rd(8'h07, 16'h0625);
        wr(8'h07, 16'h065E);
        lvl(16'h0097);
        chk("arm", {14'h0, arm_enable_r}, 16'h0002);
        wr(8'h07, 16'h08E4);
        @(posedge core_clk);
        learn_valid <= 1;
        learn_level <= 4'h9;
        @(posedge core_clk);
        learn_valid <= 0;
        wr(8'h07, 16'h0A24);
        rd(8'h07, 16'h0A64);
        lvl(16'h0099);
        wr(8'h20, 16'hFFFF);
        rd(8'h20, 16'h0000);
        rd(8'h05, 16'hA5C3);
        print_verdict;
    end
endmodule
`default_nettype wire
